// ==== core/dqtc_top.sv ====
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dqtc_top (
  input  wire logic         hclk,             // 200 mhz, one tck
  input  wire logic         hresetn,          // async, active low
  input  wire logic         hsel,             // ahb-lite select
  input  wire logic [31:0]  haddr,            // byte address
  input  wire logic [1:0]   htrans,           // transfer type
  input  wire logic         hwrite,           // write when high
  input  wire logic [2:0]   hsize,            // word only
  input  wire logic [31:0]  hwdata,           // write data
  input  wire logic         hready,           // bus ready in
  output logic [31:0]       hrdata,           // read data
  output logic              hreadyout,        // always ready
  output logic              hresp,            // always okay
  input  wire logic         wr_first_beat,    // write-1 or masked write-1 sampled
  input  wire logic         cas2_beat,        // second column command beat sampled
  output logic              dq_term_en,       // data pins terminated
  output logic              dmi_term_en,      // data mask/inversion pin terminated
  output logic              strobe_term_en,   // strobe pair terminated
  output logic [2:0]        termination_resistance  // active code, 0 when off
);
  import dqtc_pkg::*;

  // ****************************************************************
  // state, one packed struct
  // ****************************************************************
  typedef struct packed {
    logic [2:0]       field;      // termination field
    logic             set_b;      // latency set b
    logic             bl32;       // burst length 32
    logic [2:0]       bin;        // frequency bin
    logic             wl;         // write leveling
    logic             pd;         // power-down
    logic             sr;         // self-refresh
    logic             wr_pend;    // write data phase pending
    logic [ADDR_W-1:0] wr_addr;   // latched write address
    logic [31:0]      rdata;      // read data register
    dqtc_state_e_t    st;         // sequencer state
    logic             armed;      // write-1 seen, waiting second beat
    logic             hold;       // keep on across a restarted burst
    logic [LAT_W-1:0] cnt;        // cycles since second beat
    logic             dq_on;      // data termination on
    logic             dqs_on;     // strobe termination on
  } dqtc_state_t;

  dqtc_state_t s_q;  // registered state
  dqtc_state_t s_d;  // next state

  logic [LAT_W-1:0] on_lat;     // current turn-on latency
  logic [LAT_W-1:0] off_lat;    // current turn-off latency
  logic             lat_valid;  // bin defined for this set
  logic             field_ok;   // field selects a resistance
  logic             mode_en;    // termination can be applied now
  logic             addr_ok;    // accepted address phase
  logic [ADDR_W-1:0] addr_w;    // decoded address bits

  // ****************************************************************
  // helpers
  // ****************************************************************
  // resistance for a field code, zero for off and reserved
  function automatic logic [7:0] field_ohms(input logic [2:0] f);
    logic [7:0] ohms;
    ohms = 8'h00;
    case (f)
      3'h1:    ohms = CAL_REF_OHMS;         // 240
      3'h2:    ohms = CAL_REF_OHMS / 8'h02; // 120
      3'h3:    ohms = CAL_REF_OHMS / 8'h03; // 80
      3'h4:    ohms = CAL_REF_OHMS / 8'h04; // 60
      3'h5:    ohms = CAL_REF_OHMS / 8'h05; // 48
      3'h6:    ohms = CAL_REF_OHMS / 8'h06; // 40
      default: ohms = 8'h00;                // no resistance
    endcase
    return ohms;
  endfunction

  // code usable as a resistance selection
  function automatic logic field_usable(input logic [2:0] f);
    return (f != FIELD_OFF) && (f != FIELD_RESERVED);
  endfunction

  // ****************************************************************
  // latency lookup
  // ****************************************************************
  dqtc_latency u_lat (
    .bin       (s_q.bin),
    .set_b     (s_q.set_b),
    .bl32      (s_q.bl32),
    .on_lat    (on_lat),
    .off_lat   (off_lat),
    .lat_valid (lat_valid)
  );

  // mode gating: usable field and neither low power state
  assign field_ok = field_usable(s_q.field);
  assign mode_en  = field_ok && !s_q.pd && !s_q.sr;
  // address phase taken when selected, ready and neither idle nor busy
  assign addr_ok  = hsel && hready && htrans[1];
  assign addr_w   = haddr[ADDR_W-1:0];

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    // everything holds unless a branch below says otherwise
    s_d = s_q;
    // bus: read data is caught in the address phase
    if (addr_ok && !hwrite) begin
      case (addr_w)
        // control fields as last written
        CTRL_OFS: begin
          s_d.rdata = 32'h0;
          s_d.rdata[CTRL_FIELD_LSB +: 3] = s_q.field;
          s_d.rdata[CTRL_SETB_BIT]       = s_q.set_b;
          s_d.rdata[CTRL_BL32_BIT]       = s_q.bl32;
          s_d.rdata[CTRL_BIN_LSB +: 3]   = s_q.bin;
          s_d.rdata[CTRL_WL_BIT]         = s_q.wl;
          s_d.rdata[CTRL_PD_BIT]         = s_q.pd;
          s_d.rdata[CTRL_SR_BIT]         = s_q.sr;
        end
        // live state of the sequencer and pins
        STATUS_OFS: begin
          s_d.rdata = 32'h0;
          s_d.rdata[STAT_DQ_BIT]         = s_q.dq_on;
          s_d.rdata[STAT_DQS_BIT]        = s_q.dqs_on;
          s_d.rdata[STAT_EN_BIT]         = mode_en && lat_valid;
          s_d.rdata[STAT_RUN_BIT]        = (s_q.st == ST_RUN);
          s_d.rdata[STAT_OHMS_LSB +: 8]  = field_ohms(s_q.field);
        end
        // unmapped reads return zero
        default: s_d.rdata = 32'h0;
      endcase
    end
    // bus: write data phase follows the address phase
    s_d.wr_pend = addr_ok && hwrite;
    if (addr_ok && hwrite) begin
      s_d.wr_addr = addr_w;
    end
    if (s_q.wr_pend && (s_q.wr_addr == CTRL_OFS)) begin
      s_d.field = hwdata[CTRL_FIELD_LSB +: 3];
      s_d.set_b = hwdata[CTRL_SETB_BIT];
      s_d.bl32  = hwdata[CTRL_BL32_BIT];
      s_d.bin   = hwdata[CTRL_BIN_LSB +: 3];
      s_d.wl    = hwdata[CTRL_WL_BIT];
      s_d.pd    = hwdata[CTRL_PD_BIT];
      s_d.sr    = hwdata[CTRL_SR_BIT];
    end

    // sequencer: first beat arms, second beat starts the count
    if (wr_first_beat && mode_en && lat_valid && !s_q.wl) begin
      s_d.armed = 1'b1;
    end
    // idle waits for the second beat, run counts from it
    case (s_q.st)
      ST_IDLE: begin
        s_d.dq_on = 1'b0;
        s_d.hold  = 1'b0;
        // second beat of an armed write starts the count
        if (s_q.armed && cas2_beat) begin
          s_d.st    = ST_RUN;
          s_d.cnt   = '0;
          s_d.armed = wr_first_beat && mode_en && lat_valid && !s_q.wl;
        end
      end
      ST_RUN: begin
        if (s_q.armed && cas2_beat) begin
          // back-to-back write restarts the count, on stays on
          s_d.cnt   = '0;
          s_d.hold  = s_q.dq_on;
          s_d.armed = wr_first_beat && mode_en && lat_valid && !s_q.wl;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
        // turn-on point reached
        if (s_d.cnt == on_lat) begin
          s_d.dq_on = 1'b1;
          s_d.hold  = 1'b0;
        end
        // turn-off point reached, back to idle
        if (s_d.cnt == off_lat) begin
          s_d.st    = ST_IDLE;
          s_d.dq_on = 1'b0;
          s_d.hold  = 1'b0;
        end
      end
      // unreachable encoding falls back to idle
      default: begin
        s_d.st    = ST_IDLE;
        s_d.dq_on = 1'b0;
      end
    endcase
    // leaving the mode kills any burst; field, power and leveling settings
    // written at this edge count at once, a new bin or set a cycle later
    if (!field_usable(s_d.field) || s_d.pd || s_d.sr || !lat_valid || s_d.wl) begin
      s_d.st    = ST_IDLE;
      s_d.armed = 1'b0;
      s_d.dq_on = 1'b0;
      s_d.hold  = 1'b0;
    end
    // strobes: leveling terminates them alone, else they track data
    if (s_d.wl) begin
      s_d.dqs_on = field_usable(s_d.field) && !s_d.pd && !s_d.sr;
    end else begin
      s_d.dqs_on = s_d.dq_on || s_d.hold;
    end
    // a restarted burst keeps the pins on; the kill above clears hold
    if (s_d.hold) begin
      s_d.dq_on = 1'b1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // asynchronous reset loads constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q       <= '0;
      s_q.field <= CTRL_RESET[CTRL_FIELD_LSB +: 3];
      s_q.st    <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hrdata                 = s_q.rdata;
  // the bus is answered at once and never sees an error
  assign hreadyout              = 1'b1;     // zero wait states
  assign hresp                  = 1'b0;     // always okay
  assign dq_term_en             = s_q.dq_on;
  assign dmi_term_en            = s_q.dq_on;
  assign strobe_term_en         = s_q.dqs_on;
  assign termination_resistance = (s_q.dq_on || s_q.dqs_on) ? s_q.field : FIELD_OFF;

  // ****************************************************************
  // assertions
  // ****************************************************************
  // count taken up from idle
  sequence burst_start_s;
    (s_q.st == ST_IDLE) && s_q.armed && cas2_beat && mode_en && lat_valid && !s_q.wl;
  endsequence

  // conditions unchanged through the early part of a burst
  sequence quiet_s;
    (mode_en && !s_q.wl && !cas2_beat && !s_q.pd)[*3];
  endsequence

  // second beat of a new write while the pins are on
  sequence restart_s;
    (s_q.st == ST_RUN) && s_q.armed && cas2_beat && dq_term_en;
  endsequence

  // a zero field keeps every pin unterminated
  zero_field_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.field == FIELD_OFF) |-> !dq_term_en && !strobe_term_en)
    else $error("termination on with field zero");

  // the reserved code behaves like off
  reserved_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.field == FIELD_RESERVED) |-> !dq_term_en && !strobe_term_en)
    else $error("termination on with reserved field");

  // no termination in either low-power state
  low_power_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.pd || s_q.sr) |-> !dq_term_en && !strobe_term_en)
    else $error("termination on in power-down or self-refresh");

  // leveling never terminates data or mask
  level_dq_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.wl |-> !dq_term_en && !dmi_term_en)
    else $error("data termination on during write leveling");

  // leveling with a usable field terminates the strobes
  level_strobe_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.wl && mode_en) |=> strobe_term_en || !mode_en || !s_q.wl)
    else $error("strobe termination missing in write leveling");

  // mask follows data, strobes cover both
  joint_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (dmi_term_en == dq_term_en) && (dq_term_en -> strobe_term_en))
    else $error("data, mask and strobe termination differ");

  // nothing turns on in the first cycles of a burst
  idle_high_z_a: assert property (@(posedge hclk) disable iff (!hresetn)
    burst_start_s ##1 quiet_s |-> !dq_term_en)
    else $error("termination on before the turn-on latency");

  // turn-on lands exactly on the latency count
  turn_on_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(dq_term_en) && !$past(s_q.hold)) |-> (s_q.cnt == on_lat) && (s_q.st == ST_RUN))
    else $error("termination turned on off its latency");

  // turn-off lands exactly on the latency count
  turn_off_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(dq_term_en) && $past(mode_en) && mode_en && !s_q.wl) |-> ($past(s_q.cnt) + 1'b1 == off_lat))
    else $error("termination turned off off its latency");

  // every burst ends within the longest turn-off latency
  burst_ends_a: assert property (@(posedge hclk) disable iff (!hresetn)
    burst_start_s |-> ##[1:53] (s_q.st == ST_IDLE))
    else $error("termination burst never ended");

  // long bursts push only the turn-off point
  bl32_extra_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (lat_valid && s_q.bl32) |-> (off_lat == (s_q.set_b ? OFF_LAT_B[s_q.bin] : OFF_LAT_A[s_q.bin]) + BL32_EXTRA))
    else $error("burst length 32 turn-off latency wrong");

  // the code shown is the field while data is terminated
  code_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dq_term_en |-> (termination_resistance == s_q.field) && (field_ohms(s_q.field) != 8'h00))
    else $error("resistance code does not match field");

  // a write with the mode usable arms the sequencer
  write_arms_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_first_beat && mode_en && lat_valid && !s_q.wl) |=> s_q.armed || !mode_en)
    else $error("write command did not arm termination");

  // data termination needs a usable field
  field_enables_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dq_term_en |-> field_usable(s_q.field))
    else $error("termination on without a usable field");

  // back in idle the data and mask pins are high impedance
  idle_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.st == ST_IDLE) |-> !dq_term_en && !dmi_term_en)
    else $error("data termination on while idle");

  // strobes match data whenever leveling is off
  strobe_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_q.wl |-> (strobe_term_en == dq_term_en))
    else $error("strobe termination differs from data termination");

  // a write with the mode unusable leaves nothing armed
  refuse_arm_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_first_beat && !mode_en) |=> !s_q.armed)
    else $error("write armed termination with the mode unusable");

  // a second write while on never drops the pins
  restart_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    restart_s ##0 (mode_en && lat_valid && !s_q.wl && !s_q.wr_pend) |=> dq_term_en)
    else $error("termination dropped on a restarted burst");

endmodule
`default_nettype wire

// ==== core/dqtc_pkg.sv ====
package dqtc_pkg;

  // ****************************************************************
  // register map (byte addresses on the ahb-lite bus)
  // ****************************************************************
  localparam logic [3:0] CTRL_OFS   = 4'h0;  // termination mode register
  localparam logic [3:0] STATUS_OFS = 4'h4;  // live termination state
  localparam int         ADDR_LSB   = 2;     // word aligned registers
  localparam int         ADDR_W     = 4;     // decoded address bits

  // ****************************************************************
  // control register field positions
  // ****************************************************************
  localparam int CTRL_FIELD_LSB = 0;   // termination field, 3 bits
  localparam int CTRL_SETB_BIT  = 3;   // write latency set b
  localparam int CTRL_BL32_BIT  = 4;   // burst length 32
  localparam int CTRL_BIN_LSB   = 5;   // frequency bin, 3 bits
  localparam int CTRL_WL_BIT    = 8;   // write leveling mode
  localparam int CTRL_PD_BIT    = 9;   // power-down
  localparam int CTRL_SR_BIT    = 10;  // self-refresh
  localparam logic [10:0] CTRL_RESET = 11'h000;  // termination disabled

  // ****************************************************************
  // status register field positions
  // ****************************************************************
  localparam int STAT_DQ_BIT    = 0;   // data pin termination on
  localparam int STAT_DQS_BIT   = 1;   // strobe termination on
  localparam int STAT_EN_BIT    = 2;   // termination mode usable
  localparam int STAT_RUN_BIT   = 3;   // latency counter running
  localparam int STAT_OHMS_LSB  = 8;   // decoded resistance, 8 bits

  // ****************************************************************
  // termination field codes and resistance
  // ****************************************************************
  localparam logic [2:0] FIELD_OFF      = 3'h0;
  localparam logic [2:0] FIELD_RESERVED = 3'h7;
  localparam logic [7:0] CAL_REF_OHMS   = 8'hf0;  // 240 ohm reference

  // ****************************************************************
  // latency tables in clock cycles, index = frequency bin
  // bins: 0 10-266, 1 266-533, 2 533-800, 3 800-1066,
  //       4 1066-1333, 5 1333-1600, 6 1600-1866, 7 1866-2133 mhz
  // ****************************************************************
  localparam int LAT_W = 6;
  localparam logic [7:0][LAT_W-1:0] ON_LAT_A  = {6'd8, 6'd6, 6'd6, 6'd4,
                                                 6'd4, 6'd0, 6'd0, 6'd0};
  localparam logic [7:0][LAT_W-1:0] ON_LAT_B  = {6'd24, 6'd20, 6'd18, 6'd14,
                                                 6'd12, 6'd6, 6'd0, 6'd0};
  localparam logic [7:0][LAT_W-1:0] OFF_LAT_A = {6'd28, 6'd26, 6'd24, 6'd22,
                                                 6'd20, 6'd0, 6'd0, 6'd0};
  localparam logic [7:0][LAT_W-1:0] OFF_LAT_B = {6'd44, 6'd40, 6'd36, 6'd32,
                                                 6'd28, 6'd22, 6'd0, 6'd0};
  localparam logic [7:0] VALID_A = 8'hf8;  // set a defined from 800 mhz
  localparam logic [7:0] VALID_B = 8'hfc;  // set b defined from 533 mhz
  localparam logic [LAT_W-1:0] BL32_EXTRA = 6'd8;

  // sequencer states
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} dqtc_state_e_t;

endpackage

// ==== core/dqtc_latency.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// latency lookup for the selected bin, set and burst length
// ****************************************************************
module dqtc_latency (
  input  wire logic [2:0]                 bin,       // frequency bin
  input  wire logic                       set_b,     // write latency set b
  input  wire logic                       bl32,      // burst length 32
  output logic [dqtc_pkg::LAT_W-1:0]      on_lat,    // cycles to turn-on
  output logic [dqtc_pkg::LAT_W-1:0]      off_lat,   // cycles to turn-off
  output logic                            lat_valid  // bin has latencies
);
  import dqtc_pkg::*;

  // table pick, no entries below the lowest defined bin
  always_comb begin
    if (set_b) begin
      on_lat    = ON_LAT_B[bin];
      off_lat   = OFF_LAT_B[bin];
      lat_valid = VALID_B[bin];
    end else begin
      on_lat    = ON_LAT_A[bin];
      off_lat   = OFF_LAT_A[bin];
      lat_valid = VALID_A[bin];
    end
    // longer burst stretches only the turn-off point
    if (bl32) begin
      off_lat = off_lat + BL32_EXTRA;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/dqtc_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// memory controller side: issues write commands to the lane
// ****************************************************************
module dqtc_ctrl_model (
  input  wire logic hclk,           // command clock, one tck
  output logic      wr_first_beat,  // write-1 or masked write-1
  output logic      cas2_beat       // second column command beat
);
  // command bus idles low
  initial begin
    wr_first_beat = 1'b0;
    cas2_beat     = 1'b0;
  end

  // first beat, then gap idle cycles (prompt or slow), then second beat
  task automatic send(input int gap);
    @(posedge hclk);
    wr_first_beat <= 1'b1;
    @(posedge hclk);
    wr_first_beat <= 1'b0;
    repeat (gap) @(posedge hclk);
    cas2_beat <= 1'b1;
    @(posedge hclk);
    cas2_beat <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/dqtc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dqtc_top_tb;
  import dqtc_pkg::*;
  // one expected change of the termination pins
  typedef struct {int cyc; logic [2:0] v; logic [2:0] r;} dqtc_note_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;  // bus control
  logic [31:0] haddr, hwdata, hrdata;                   // bus data
  logic [1:0]  htrans;                                  // transfer type
  logic [2:0]  hsize, termination_resistance, cur, prev; // sizes, codes
  logic        dq_term_en, dmi_term_en, strobe_term_en; // pin enables
  logic        wr_first_beat, cas2_beat;                // command beats
  wire logic   hready;                                  // single slave
  logic [31:0] seed = 32'h00012b92;                     // xorshift state
  int          failures, checked, cyc, e1, e2, i, j;    // counters
  logic [31:0] rd_q[$];                                 // expected reads
  dqtc_note_t  term_q[$];                               // expected edges
  dqtc_note_t  nt;                                      // popped note
  event        rd_ev;                                   // read data taken
  int on_a[8] = '{0, 0, 0, 4, 4, 6, 6, 8};
  int on_b[8] = '{0, 0, 6, 12, 14, 18, 20, 24};
  int off_a[8] = '{0, 0, 0, 20, 22, 24, 26, 28};
  int off_b[8] = '{0, 0, 22, 28, 32, 36, 40, 44};
  assign hready = hreadyout;

  dqtc_top dqtc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .wr_first_beat(wr_first_beat), .cas2_beat(cas2_beat), .dq_term_en(dq_term_en),
    .dmi_term_en(dmi_term_en), .strobe_term_en(strobe_term_en), .termination_resistance(termination_resistance));
  dqtc_ctrl_model dqtc_ctrl_model_inst (.hclk(hclk), .wr_first_beat(wr_first_beat), .cas2_beat(cas2_beat));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // resistance in ohms for a field code, zero when undefined
  function automatic logic [7:0] ohms(input logic [2:0] f);
    return (f == 3'h0 || f == 3'h7) ? 8'h00 : 8'hf0 / {5'h0, f};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single ahb-lite transfer; for a read d is the expected data
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    if (!w) rd_q.push_back(d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    if (!w) -> rd_ev;
  endtask
  // program the lane, read status back, issue one write, note edges
  task automatic burst(input logic [2:0] f, input logic sb, input logic bl, input logic [2:0] b,
                       input logic [1:0] m, input int gap);
    int on, off, e;
    logic ok;
    on = sb ? on_b[b] : on_a[b];
    off = (sb ? off_b[b] : off_a[b]) + (bl ? 8 : 0);
    ok = (f != 3'h0) && (f != 3'h7) && (on != 0) && (m == 2'b00);
    bus(1'b1, 32'h0, {21'h0, m, 1'b0, b, bl, sb, f});
    bus(1'b0, 32'h0, {21'h0, m, 1'b0, b, bl, sb, f});
    bus(1'b0, 32'h4, {16'h0, ohms(f), 5'h0, ok, 2'b00});
    dqtc_ctrl_model_inst.send(gap);
    e = cyc + 1;
    if (ok) begin
      term_q.push_back('{e + on, 3'b111, f});
      term_q.push_back('{e + off, 3'b000, f});
    end
    repeat (off + 8) @(posedge hclk);
  endtask
  task automatic test_done();
    if (term_q.size() != 0 || rd_q.size() != 0) failures++;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // clock, cycle count and monitors
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  // read data compared with the oldest expected read
  always @(rd_ev) begin
    chk("read data", rd_q.pop_front(), hrdata);
    chk("response", 32'h0, {31'h0, hresp});
  end
  // every change of the termination pins must match the oldest note
  always @(posedge hclk) begin
    #1;
    cur = {strobe_term_en, dmi_term_en, dq_term_en};
    if (cur !== prev) begin
      if (term_q.size() == 0) chk("unexpected termination", {29'h0, prev}, {29'h0, cur});
      else begin
        nt = term_q.pop_front();
        chk("termination pins", {29'h0, nt.v}, {29'h0, cur});
        if (nt.cyc >= 0) chk("termination cycle", nt.cyc, cyc);
        chk("termination code", {29'h0, (nt.v != 3'b000) ? nt.r : 3'h0}, {29'h0, termination_resistance});
      end
      prev = cur;
    end
  end
  // watchdog for a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    test_done();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {hsel, hwrite, hresetn} = 3'b000;
    {haddr, hwdata, htrans, hsize} = '0;
    {failures, checked, cyc} = '0;
    prev = 3'b000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0, 32'h0);
    bus(1'b1, 32'h4, 32'h0000ffff);
    bus(1'b0, 32'h4, 32'h0);
    bus(1'b1, 32'h8, 32'h000000e3);
    bus(1'b0, 32'h8, 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    // every field code, including disabled and reserved
    for (i = 0; i < 8; i++) burst(3'(i), 1'b0, 1'b0, 3'h7, 2'b00, int'(rnd() % 4));
    // every bin of both latency sets, random code and burst length
    for (j = 0; j < 2; j++)
      for (i = 0; i < 8; i++) burst(3'(1 + rnd() % 6), j[0], 1'(rnd()), 3'(i), 2'b00, int'(rnd() % 4));
    burst(3'h3, 1'b0, 1'b1, 3'h7, 2'b01, 1);
    burst(3'h3, 1'b0, 1'b0, 3'h7, 2'b10, 1);
    // second write while running restarts the off count
    bus(1'b1, 32'h0, {21'h0, 2'b00, 1'b0, 3'h3, 2'b00, 3'h4});
    dqtc_ctrl_model_inst.send(0);
    e1 = cyc + 1;
    term_q.push_back('{e1 + 4, 3'b111, 3'h4});
    repeat (5) @(posedge hclk);
    dqtc_ctrl_model_inst.send(0);
    e2 = cyc + 1;
    term_q.push_back('{e2 + 20, 3'b000, 3'h4});
    repeat (30) @(posedge hclk);
    // write leveling: strobes only, data never
    term_q.push_back('{-1, 3'b100, 3'h2});
    bus(1'b1, 32'h0, {21'h0, 2'b00, 1'b1, 3'h7, 2'b00, 3'h2});
    dqtc_ctrl_model_inst.send(1);
    repeat (40) @(posedge hclk);
    term_q.push_back('{-1, 3'b000, 3'h0});
    bus(1'b1, 32'h0, {21'h0, 2'b00, 1'b1, 3'h7, 2'b00, 3'h0});
    dqtc_ctrl_model_inst.send(1);
    repeat (40) @(posedge hclk);
    test_done();
  end
endmodule
`default_nettype wire
